// ===== css_map.vh
// register map and field layout of the clocked synchronous serial port
`ifndef CSS_MAP_VH
`define CSS_MAP_VH
`define CSS_IDX_MODE 8'hB0
`define CSS_IDX_UPPER 8'hB1
`define CSS_IDX_LOWER 8'hB2
`define CSS_IDX_LAST 8'hB3
`define CSS_IDX_CTRL 8'hB4
`define CSS_IDX_IRQ_STAT 8'hB5
`define CSS_IDX_IRQ_CLR 8'hB6
`define CSS_IDX_IRQ_EN 8'hB7
`define CSS_MODE_RESET 8'h80
`define CSS_MODE_WIDE_BIT 6
`define CSS_MODE_SUB_HI 5
`define CSS_MODE_SUB_LO 4
`define CSS_MODE_EXT_BIT 3
`define CSS_MODE_DIV_HI 2
`define CSS_MODE_DIV_LO 0
`define CSS_CLKSEL_EXT 4'h8
`define CSS_LAST_BIT 7
`define CSS_LAST_RSVD 7'h7F
`define CSS_CTRL_START_BIT 0
`define CSS_CTRL_BUSY_BIT 0
`define CSS_EV_DONE 0
`define CSS_EV_COLL 1
`define CSS_EV_W 2
`define CSS_LEN_NARROW 5'h08
`define CSS_LEN_WIDE 5'h10
`define CSS_DATA_RESET 8'h00
`endif

// ===== css_clk_div.v
// system clock prescaler giving internal shift clock half-period ticks
`timescale 1ns/1ps
`default_nettype none
module css_clk_div #(
	parameter CNT_W = 10
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [2:0] divSel,
	output wire halfTick
);
	reg [CNT_W-1:0] cnt_r;

	// half period mask for divide by 1024, 256, 64, 32, 16, 8, 4, 2
	function [CNT_W-1:0] halfMask;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: halfMask = 10'h1FF;
				3'h1: halfMask = 10'h07F;
				3'h2: halfMask = 10'h01F;
				3'h3: halfMask = 10'h00F;
				3'h4: halfMask = 10'h007;
				3'h5: halfMask = 10'h003;
				3'h6: halfMask = 10'h001;
				default: halfMask = 10'h000;
			endcase
		end
	endfunction

	always @(posedge clk_sys)
	begin
		if (sys_rst)
			cnt_r <= {CNT_W{1'b0}};
		else
			cnt_r <= cnt_r + 1'b1;
	end

	assign halfTick = ((cnt_r & halfMask(divSel)) == halfMask(divSel));
endmodule
`default_nettype wire

// ===== css_irq.v
// sticky event status, enable mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module css_irq #(
	parameter EV_W = 2
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [EV_W-1:0] evPulse,
	input wire [EV_W-1:0] clrMask,
	input wire clrWrite,
	input wire [EV_W-1:0] enData,
	input wire enWrite,
	output wire [EV_W-1:0] statusOut,
	output wire [EV_W-1:0] enableOut,
	output wire irqOut
);
	reg [EV_W-1:0] stat_r;
	reg [EV_W-1:0] en_r;
	wire [EV_W-1:0] clrNow;

	assign clrNow = clrWrite ? clrMask : {EV_W{1'b0}};

	// a new event wins over a clear in the same cycle
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			stat_r <= {EV_W{1'b0}};
			en_r <= {EV_W{1'b0}};
		end
		else
		begin
			stat_r <= (stat_r & ~clrNow) | evPulse;
			if (enWrite)
				en_r <= enData;
		end
	end

	assign statusOut = stat_r;
	assign enableOut = en_r;
	assign irqOut = |(stat_r & en_r);
endmodule
`default_nettype wire

// ===== css_port.v
// clocked synchronous serial port with avalon-mm register slave
//
// Overview of operation
// - external source: clock pin is input, shifting follows the remote clock
// - data registers hold transmit word, then the received word
// - 8-bit mode: upper byte register neither shifts nor loads
// - 16-bit mode: upper byte register is the high eight bits
// - 8-bit mode: lower byte register is the whole data register
// - 16-bit mode: lower byte register is the low eight bits
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "css_map.vh"
module css_port #(
	parameter ADDR_W = 10
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	output wire shiftClkOut,
	output wire shiftClkOe,
	input wire shiftClkIn,
	output wire serialOut,
	input wire serialIn,
	output wire irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_CONT = 3'b100;

	reg ack_r;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;
	reg [7:0] mode_r;
	reg [7:0] upper_r;
	reg [7:0] lower_r;
	reg lastBit_r;
	reg [2:0] state_r;
	reg [15:0] shift_r;
	reg [4:0] count_r;
	reg wide_r;
	reg sclk_r;
	reg sout_r;
	reg extPrev_r;
	reg doneEv;
	reg collEv;

	wire [7:0] regIdx;
	wire wrEn;
	wire busy;
	wire wrMode;
	wire wrUpper;
	wire wrLower;
	wire wrLast;
	wire wrCtrl;
	wire startReq;
	wire modeCont;
	wire modeWide;
	wire intClk;
	wire extClk;
	wire halfTick;
	wire fallEv;
	wire riseEv;
	wire [4:0] wordLen;
	wire [1:0] irqStat;
	wire [1:0] irqEn;

	// word index of the byte address
	assign regIdx = avs_address[9:2];

	// one wait state on every access
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wrEn = avs_write & ack_r & avs_byteenable[0];
	assign avs_readdata = rdata_r;

	always @(posedge clk_sys)
	begin
		if (sys_rst)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	function isHit;
		input [7:0] idx;
		input [7:0] target;
		begin
			isHit = (idx == target);
		end
	endfunction

	assign busy = (state_r == ST_SHIFT);
	assign wrMode = wrEn & isHit(regIdx, `CSS_IDX_MODE);
	assign wrUpper = wrEn & isHit(regIdx, `CSS_IDX_UPPER);
	assign wrLower = wrEn & isHit(regIdx, `CSS_IDX_LOWER);
	assign wrLast = wrEn & isHit(regIdx, `CSS_IDX_LAST);
	assign wrCtrl = wrEn & isHit(regIdx, `CSS_IDX_CTRL);
	assign startReq = wrCtrl & avs_writedata[`CSS_CTRL_START_BIT];

	// mode field decode
	assign modeCont = (mode_r[`CSS_MODE_SUB_HI:`CSS_MODE_SUB_LO] == 2'h0);
	assign modeWide = mode_r[`CSS_MODE_WIDE_BIT];
	assign intClk = ~mode_r[`CSS_MODE_EXT_BIT];
	assign extClk = (mode_r[3:0] == `CSS_CLKSEL_EXT);
	assign wordLen = wide_r ? `CSS_LEN_WIDE : `CSS_LEN_NARROW;

	// read data captured in the wait cycle
	always @*
	begin
		rdata_nxt = 32'h00000000;
		case (regIdx)
			`CSS_IDX_UPPER: rdata_nxt[7:0] = upper_r;
			`CSS_IDX_LOWER: rdata_nxt[7:0] = lower_r;
			`CSS_IDX_LAST: rdata_nxt[7:0] = {lastBit_r, `CSS_LAST_RSVD};
			`CSS_IDX_CTRL: rdata_nxt[`CSS_CTRL_BUSY_BIT] = busy;
			`CSS_IDX_IRQ_STAT: rdata_nxt[1:0] = irqStat;
			`CSS_IDX_IRQ_EN: rdata_nxt[1:0] = irqEn;
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (sys_rst)
			rdata_r <= 32'h00000000;
		else if (avs_read & ~ack_r)
			rdata_r <= rdata_nxt;
	end

	// mode and last-bit control
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mode_r <= `CSS_MODE_RESET;
			lastBit_r <= 1'b0;
		end
		else
		begin
			if (wrMode & ~busy)
				mode_r <= avs_writedata[7:0];
			if (wrLast)
				lastBit_r <= avs_writedata[`CSS_LAST_BIT];
		end
	end

	css_clk_div #(
		.CNT_W(10)
	) u_div (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.divSel(mode_r[`CSS_MODE_DIV_HI:`CSS_MODE_DIV_LO]),
		.halfTick(halfTick)
	);

	// shift clock edges from prescaler or from the clock pin
	assign fallEv = intClk ? (halfTick & sclk_r) :
		(extClk & extPrev_r & ~shiftClkIn);
	assign riseEv = intClk ? (halfTick & ~sclk_r) :
		(extClk & ~extPrev_r & shiftClkIn);

	always @(posedge clk_sys)
	begin
		if (sys_rst)
			extPrev_r <= 1'b1;
		else
			extPrev_r <= shiftClkIn;
	end

	// data registers: cpu writes when idle, results loaded at transfer end
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			upper_r <= `CSS_DATA_RESET;
			lower_r <= `CSS_DATA_RESET;
		end
		else if (busy)
		begin
			if (riseEv & (count_r == wordLen - 5'h01))
			begin
				if (wide_r)
				begin
					upper_r <= {serialIn, shift_r[15:9]};
					lower_r <= shift_r[8:1];
				end
				else
					lower_r <= {serialIn, shift_r[7:1]};
			end
		end
		else
		begin
			if (wrUpper)
				upper_r <= avs_writedata[7:0];
			if (wrLower)
				lower_r <= avs_writedata[7:0];
		end
	end

	// shift engine, lsb first, out on falling and in on rising edge
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			shift_r <= 16'h0000;
			count_r <= 5'h00;
			wide_r <= 1'b0;
			sclk_r <= 1'b1;
			sout_r <= 1'b0;
			doneEv <= 1'b0;
			collEv <= 1'b0;
		end
		else
		begin
			doneEv <= 1'b0;
			collEv <= busy & (wrUpper | wrLower | wrMode | startReq);
			case (state_r)
				ST_IDLE:
				begin
					sclk_r <= 1'b1;
					sout_r <= lastBit_r;
					if (startReq & ~modeCont)
					begin
						state_r <= ST_SHIFT;
						wide_r <= modeWide;
						count_r <= 5'h00;
						shift_r <= modeWide ? {upper_r, lower_r} :
							{8'h00, lower_r};
					end
					else if (modeCont & intClk)
						state_r <= ST_CONT;
				end
				ST_SHIFT:
				begin
					if (intClk & halfTick)
						sclk_r <= ~sclk_r;
					if (fallEv)
						sout_r <= shift_r[0];
					if (riseEv)
					begin
						if (wide_r)
							shift_r <= {serialIn, shift_r[15:1]};
						else
							shift_r <= {8'h00, serialIn, shift_r[7:1]};
						if (count_r == wordLen - 5'h01)
						begin
							state_r <= ST_IDLE;
							// final bit held past the last rise; idle restores level
							doneEv <= 1'b1;
						end
						else
							count_r <= count_r + 5'h01;
					end
				end
				ST_CONT:
				begin
					sout_r <= lastBit_r;
					if (halfTick)
						sclk_r <= ~sclk_r;
					if (~(modeCont & intClk))
					begin
						state_r <= ST_IDLE;
						sclk_r <= 1'b1;
					end
				end
				default:
				begin
					state_r <= ST_IDLE;
					sclk_r <= 1'b1;
				end
			endcase
		end
	end

	assign shiftClkOut = sclk_r;
	assign shiftClkOe = intClk;
	assign serialOut = sout_r;

	css_irq #(
		.EV_W(`CSS_EV_W)
	) u_irq (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.evPulse({collEv, doneEv}),
		.clrMask(avs_writedata[1:0]),
		.clrWrite(wrEn & isHit(regIdx, `CSS_IDX_IRQ_CLR)),
		.enData(avs_writedata[1:0]),
		.enWrite(wrEn & isHit(regIdx, `CSS_IDX_IRQ_EN)),
		.statusOut(irqStat),
		.enableOut(irqEn),
		.irqOut(irq)
	);
endmodule
`default_nettype wire

// ===== css_port_chk.sv
// bus and pin assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
module css_port_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic shiftClkOut,
	input wire logic shiftClkOe,
	input wire logic serialOut,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic rdAck = avs_read && !avs_waitrequest;
	chk_one_wait: assert property ($rose(avs_read || avs_write)
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("request not answered after one wait");
	chk_idle_wait: assert property (!(avs_read || avs_write)
		|-> !avs_waitrequest)
		else $error("waitrequest without request");
	chk_reset_pins: assert property (disable iff (1'b0)
		sys_rst |=> shiftClkOut && shiftClkOe && !serialOut && !irq)
		else $error("pins wrong after reset");
	chk_upper_zero: assert property (rdAck |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_unmapped_zero: assert property (rdAck && avs_address[9:2] < 8'hB0
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_mode_wo: assert property (rdAck && avs_address[9:2] == 8'hB0
		|-> avs_readdata == 32'h0)
		else $error("mode register readable");
	chk_last_rsvd: assert property (rdAck && avs_address[9:2] == 8'hB3
		|-> avs_readdata[6:0] == 7'h7F)
		else $error("last bit reserved field wrong");
	chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
endmodule
bind css_port css_port_chk i_chk (.*);
`default_nettype wire

// ===== css_peer.sv
// remote serial device: lsb first, can supply the clock
`timescale 1ns/1ps
`default_nettype none
module css_peer (
	input wire logic clk_sys,
	input wire logic sclk,
	input wire logic din,
	output var logic dout = 1'b0,
	input wire logic load,
	input wire logic [15:0] word,
	input wire logic extGo,
	output var logic extClk = 1'b1,
	output var logic [15:0] rx,
	output var logic [4:0] cnt
);
	logic [15:0] tx;
	always @(posedge load)
	begin
		tx = word;
		rx = 16'h0;
		cnt = 5'h0;
		dout = ~dout;
	end
	always @(negedge sclk)
	begin
		dout = tx[0];
		tx = tx >> 1;
	end
	always @(posedge sclk)
	begin
		rx = {din, rx[15:1]};
		cnt = cnt + 5'h1;
	end
	always @(posedge extGo)
		repeat (16)
		begin
			repeat (4) @(posedge clk_sys);
			extClk <= ~extClk;
		end
endmodule
`default_nettype wire

// ===== test_clocked_sync_serial_port.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module test_clocked_sync_serial_port;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [9:0] avs_address = 10'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	wire logic [31:0] avs_readdata;
	wire logic avs_waitrequest, shiftClkOut, shiftClkOe, serialOut;
	wire logic serialIn, irq, extClk;
	wire logic shiftClkIn = extClk;
	wire logic sclk = shiftClkOe ? shiftClkOut : extClk;
	logic load = 1'b0;
	logic extGo = 1'b0;
	logic [15:0] word = 16'h0;
	wire logic [15:0] rx;
	wire logic [4:0] cnt;
	logic [7:0] rd;
	logic [83:0] r;
	logic prevSck = 1'b1;
	int run = 0;
	int halfLen = 0;
	int miscompares = 0;
	int numChecks = 0;
	// mode upper lower peer | upper lower peer-rx half-period
	logic [83:0] rows [8] = '{84'h17A53C00C3A5C33C00001,
		84'h561234BEEFBEEF1234002, 84'h15FF800001FF018000004,
		84'h540100800080000100008, 84'h13005A00FF00FF5A00010,
		84'h52C3960F0F0F0FC396020, 84'h117701007E777E0100080,
		84'h103CFE00553C55FE00200};
	logic [15:0] regs [5] = '{16'hB100, 16'hB200, 16'hB37F, 16'hB000,
		16'h2000};
	always #25 clk_sys = ~clk_sys;
	css_port i_dut (.*);
	css_peer i_peer (.clk_sys(clk_sys), .sclk(sclk), .din(serialOut),
		.dout(serialIn), .load(load), .word(word), .extGo(extGo),
		.extClk(extClk), .rx(rx), .cnt(cnt));
	// length of the last completed shift clock phase
	always @(posedge clk_sys)
	begin
		prevSck <= shiftClkOut;
		run <= (shiftClkOut !== prevSck) ? 1 : run + 1;
		if (shiftClkOut !== prevSck)
			halfLen <= run;
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		numChecks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i, d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= {i, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
		begin
			n++;
			if (n > 99)
			begin
				miscompares++;
				conclude();
			end
			@(posedge clk_sys);
		end
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] m, u, l, input logic [15:0] pw,
		input logic lb, input logic coll);
		int n;
		bus(1, 8'hB0, m);
		bus(1, 8'hB1, u);
		bus(1, 8'hB2, l);
		bus(1, 8'hB3, {lb, 7'h0});
		word <= pw;
		load <= 1'b1;
		bus(1, 8'hB4, 8'h01);
		load <= 1'b0;
		extGo <= m[3];
		if (coll)
			bus(1, 8'hB2, 8'hFF);
		n = 0;
		do
		begin
			bus(0, 8'hB4, 8'h0);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 5000);
		extGo <= 1'b0;
		if (n >= 5000)
		begin
			miscompares++;
			conclude();
		end
	endtask
	initial
	begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk("oe", 16'(shiftClkOe), 16'h1);
		bus(1, 8'h20, 8'hFF);
		for (int k = 0; k < 5; k++)
		begin
			bus(0, regs[k][15:8], 8'h0);
			chk("reg", 16'(rd), 16'(regs[k][7:0]));
		end
		for (int k = 0; k < 8; k++)
		begin
			r = rows[k];
			xfer(r[83:76], r[75:68], r[67:60], r[59:44], k[0], 1'b0);
			bus(0, 8'hB1, 8'h0);
			chk("up", 16'(rd), 16'(r[43:36]));
			bus(0, 8'hB2, 8'h0);
			chk("lo", 16'(rd), 16'(r[35:28]));
			chk("rx", rx, r[27:12]);
			chk("half", 16'(halfLen), 16'(r[11:0]));
			chk("bits", 16'(cnt), r[82] ? 16'h10 : 16'h8);
			chk("out", 16'(serialOut), 16'(k[0]));
			bus(0, 8'hB3, 8'h0);
			chk("last", 16'(rd), 16'({k[0], 7'h7F}));
		end
		bus(1, 8'hB7, 8'h01);
		xfer(8'h18, 8'h00, 8'h81, 16'h0042, 1'b1, 1'b1);
		chk("oe", 16'(shiftClkOe), 16'h0);
		chk("rx", rx, 16'h8100);
		bus(0, 8'hB2, 8'h0);
		chk("lo", 16'(rd), 16'h42);
		avs_byteenable <= 4'hE;
		bus(1, 8'hB2, 8'h5A);
		avs_byteenable <= 4'hF;
		bus(0, 8'hB2, 8'h0);
		chk("be", 16'(rd), 16'h42);
		bus(0, 8'hB5, 8'h0);
		chk("st", 16'(rd), 16'h3);
		chk("irq", 16'(irq), 16'h1);
		bus(1, 8'hB7, 8'h00);
		@(negedge clk_sys);
		chk("irq", 16'(irq), 16'h0);
		bus(1, 8'hB7, 8'h03);
		@(negedge clk_sys);
		chk("irq", 16'(irq), 16'h1);
		bus(1, 8'hB6, 8'h03);
		@(negedge clk_sys);
		chk("irq", 16'(irq), 16'h0);
		bus(0, 8'hB5, 8'h0);
		chk("st", 16'(rd), 16'h0);
		bus(1, 8'hB0, 8'h07);
		bus(1, 8'hB4, 8'h01);
		bus(0, 8'hB4, 8'h0);
		chk("busy", 16'(rd[0]), 16'h0);
		chk("half", 16'(halfLen), 16'h1);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk("oe", 16'(shiftClkOe), 16'h1);
		chk("out", 16'(serialOut), 16'h0);
		bus(0, 8'hB2, 8'h0);
		chk("lo", 16'(rd), 16'h0);
		bus(0, 8'hB3, 8'h0);
		chk("last", 16'(rd), 16'h7F);
		conclude();
	end
endmodule
`default_nettype wire
